// file: rtl/citp_timer_pair.sv
// Cascadable pair of 8-bit interval timers with output flop, AXI4-Lite registers
//
// How it works
// - Each timer runs alone as 8-bit interval timer
// - Run bit 0 halts and zeroes counter; 1 counts
// - Per-timer clock source: lower from pin or taps, upper from lower match or taps
// - Enabled match toggles output flop driving output pin
// - Toggle source chooses lower or upper timer match
// - Upper counter advances on lower match when selected
// - Mode field 01 cascades into one 16-bit timer
// - 16-bit: upper counts lower overflow, ignoring select
// - 16-bit compare: lower low byte, upper high byte
// - Lower compare write inhibits, upper write re-enables compare
// - 16-bit: lower match neither clears nor interrupts
// - 16-bit: upper compares on each lower comparator pulse
// - Joint match clears both counters, raises upper irq
// - Joint match toggles flop when inversion enabled
// - Compare value 00 means 256, matches on overflow
// - Flop action on write: toggle, set, clear, none
// - Source select 0 lower, 1 upper; enable gates
`timescale 1ns/100ps
`include "citp_cfg.svh"
module citp_timer_pair #(
   parameter int T1_DIV = `CITP_T1_DIV
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  citp_pkg::citp_axil_req_s  axil_req,
   output citp_pkg::citp_axil_rsp_s  axil_rsp,
   input  wire logic                 external_count_pin,
   output logic                      timer_output_pin,
   output logic                      lower_match_irq,
   output logic                      upper_match_irq
);
   import citp_pkg::*;

   // -------------------------------------------------------------------------
   // Register bus and prescaler
   // -------------------------------------------------------------------------
   logic        wr_en;
   citp_addr_t  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_err;
   citp_addr_t  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   logic [3:0]  tap;

   citp_axil_slave u_slave (
      .clk     (clk),
      .rst     (rst),
      .req     (axil_req),
      .rsp     (axil_rsp),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_err),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_err  (rd_err)
   );

   citp_prescaler #(
      .T1_DIV (T1_DIV)
   ) u_pre (
      .clk (clk),
      .rst (rst),
      .tap (tap)
   );

   citp_regs_s s;
   citp_regs_s next_s;

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   logic [7:0] wb;
   logic       wr_lane;
   logic       wr_run;
   logic       wr_mode;
   logic       wr_cmp_lo;
   logic       wr_cmp_hi;
   logic       wr_ffcr;
   logic       wr_irq_en;

   assign wb        = wr_data[7:0];
   // Registers are a byte wide; upper lanes are accepted and dropped
   assign wr_lane   = wr_en && wr_strb[0];
   assign wr_run    = wr_lane && ({wr_addr[7:2], 2'b00} == `CITP_OFF_RUN);
   assign wr_mode   = wr_lane && ({wr_addr[7:2], 2'b00} == `CITP_OFF_MODE);
   assign wr_cmp_lo = wr_lane && ({wr_addr[7:2], 2'b00} == `CITP_OFF_CMP_LO);
   assign wr_cmp_hi = wr_lane && ({wr_addr[7:2], 2'b00} == `CITP_OFF_CMP_HI);
   assign wr_ffcr   = wr_lane && ({wr_addr[7:2], 2'b00} == `CITP_OFF_FFCR);
   assign wr_irq_en = wr_lane && ({wr_addr[7:2], 2'b00} == `CITP_OFF_IRQ_EN);

   always_comb begin
      wr_err = 1'b0;
      unique case ({wr_addr[7:2], 2'b00})
         `CITP_OFF_RUN, `CITP_OFF_MODE, `CITP_OFF_CMP_LO, `CITP_OFF_CMP_HI,
         `CITP_OFF_FFCR, `CITP_OFF_IRQ_EN: wr_err = 1'b0;
         // Status is read-only
         default: wr_err = 1'b1;
      endcase
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      unique case ({rd_addr[7:2], 2'b00})
         `CITP_OFF_RUN:    rd_data = {30'h0, s.run};
         `CITP_OFF_MODE:   rd_data = {24'h0, s.mode, 2'b00, s.hi_sel, s.lo_sel};
         `CITP_OFF_CMP_LO: rd_data = {24'h0, s.cmp_lo};
         `CITP_OFF_CMP_HI: rd_data = {24'h0, s.cmp_hi};
         // Bits 7:4 read as ones
         `CITP_OFF_FFCR:   rd_data = {24'h0, 4'hf, s.ff_act, s.ff_ie, s.ff_is};
         `CITP_OFF_STATUS: rd_data = {14'h0, s.cmp16_en, s.ff, s.cnt_hi, s.cnt_lo};
         `CITP_OFF_IRQ_EN: rd_data = {30'h0, s.irq_en};
         default:          rd_err  = 1'b1;
      endcase
   end

   // -------------------------------------------------------------------------
   // Count ticks and comparators
   // -------------------------------------------------------------------------
   logic       mode16;
   logic       ext_rise;
   logic       lo_src;
   logic       hi_src8;
   logic       lo_tick;
   logic       hi_tick;
   logic [7:0] lo_next;
   logic [7:0] hi_next;
   logic       lo_hit;
   logic       lo_ovf;
   logic       hi_hit8;
   logic       joint;
   logic       hw_tog;

   // PPG and PWM codes are not built and behave as the two 8-bit timers
   assign mode16   = (s.mode == CITP_MODE_16BIT);
   assign ext_rise = external_count_pin && !s.ext_d;

   always_comb begin
      lo_src = 1'b0;
      unique case (s.lo_sel)
         2'b00: lo_src = ext_rise;
         2'b01: lo_src = tap[0];
         2'b10: lo_src = tap[1];
         2'b11: lo_src = tap[2];
      endcase
   end

   always_comb begin
      hi_src8 = 1'b0;
      unique case (s.hi_sel)
         2'b00: hi_src8 = lo_hit;
         2'b01: hi_src8 = tap[0];
         2'b10: hi_src8 = tap[2];
         2'b11: hi_src8 = tap[3];
      endcase
   end

   assign lo_tick = s.run[0] && lo_src;
   assign lo_next = 8'(s.cnt_lo + 8'h01);
   // Comparing the incremented value makes 00 match on the wrap, i.e. 256
   assign lo_hit  = lo_tick && (lo_next == s.cmp_lo);
   assign lo_ovf  = lo_tick && (s.cnt_lo == 8'hff);
   assign hi_tick = s.run[1] && (mode16 ? lo_ovf : hi_src8);
   assign hi_next = 8'(s.cnt_hi + 8'h01);
   assign hi_hit8 = hi_tick && !mode16 && (hi_next == s.cmp_hi);
   // Upper compare is sampled only at a lower comparator pulse
   assign joint   = mode16 && s.run[1] && s.cmp16_en && lo_hit
                    && (s.cnt_hi == s.cmp_hi);
   assign hw_tog  = s.ff_ie && (mode16 ? joint
                                       : (s.ff_is ? hi_hit8 : lo_hit));

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      next_s       = s;
      next_s.ext_d = external_count_pin;

      if (!s.run[0]) begin
         next_s.cnt_lo = 8'h00;
      end else if ((lo_hit && !mode16) || joint) begin
         next_s.cnt_lo = 8'h00;
      end else if (lo_tick) begin
         next_s.cnt_lo = lo_next;
      end

      if (!s.run[1]) begin
         next_s.cnt_hi = 8'h00;
      end else if (hi_hit8 || joint) begin
         next_s.cnt_hi = 8'h00;
      end else if (hi_tick) begin
         next_s.cnt_hi = hi_next;
      end

      next_s.irq_lo = s.irq_en[0] && lo_hit && !mode16;
      next_s.irq_hi = s.irq_en[1] && (hi_hit8 || joint);

      next_s.ff = s.ff ^ hw_tog;
      if (wr_ffcr) begin
         next_s.ff_act = wb[`CITP_FFCR_ACT_LSB +: 2];
         next_s.ff_ie  = wb[`CITP_FFCR_IE_BIT];
         next_s.ff_is  = wb[`CITP_FFCR_IS_BIT];
         unique case (wb[`CITP_FFCR_ACT_LSB +: 2])
            2'b00: next_s.ff = !(s.ff ^ hw_tog);
            2'b01: next_s.ff = 1'b1;
            2'b10: next_s.ff = 1'b0;
            2'b11: next_s.ff = s.ff ^ hw_tog;
         endcase
      end

      if (wr_run) begin
         next_s.run = wb[1:0];
      end
      if (wr_mode) begin
         next_s.mode   = citp_mode_e'(wb[`CITP_MODE_OP_LSB +: 2]);
         next_s.hi_sel = wb[`CITP_MODE_HI_LSB +: 2];
         next_s.lo_sel = wb[`CITP_MODE_LO_LSB +: 2];
      end
      if (wr_cmp_lo) begin
         next_s.cmp_lo   = wb;
         next_s.cmp16_en = 1'b0;
      end
      if (wr_cmp_hi) begin
         next_s.cmp_hi   = wb;
         next_s.cmp16_en = 1'b1;
      end
      if (wr_irq_en) begin
         next_s.irq_en = wb[1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s          <= '0;
         s.cmp_lo   <= `CITP_RST_CMP;
         s.cmp_hi   <= `CITP_RST_CMP;
         s.cmp16_en <= `CITP_RST_CMP16_EN;
         s.ff_act   <= `CITP_RST_FF_ACT;
      end else begin
         s <= next_s;
      end
   end

   assign timer_output_pin = s.ff;
   assign lower_match_irq  = s.irq_lo;
   assign upper_match_irq  = s.irq_hi;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence seq_joint_hit;
      mode16 && s.run[1] && s.cmp16_en && lo_hit && (s.cnt_hi == s.cmp_hi);
   endsequence

   sequence seq_both_cleared;
      (s.cnt_lo == 8'h00) && (s.cnt_hi == 8'h00);
   endsequence

   a_stop_zeroes: assert property (
      !s.run[0] ##1 !s.run[0] |-> s.cnt_lo == 8'h00)
      else $error("stopped lower counter not zero");

   a_stopped_silent: assert property (
      !s.run[0] |=> !lower_match_irq && (s.cnt_lo == 8'h00))
      else $error("stopped lower timer produced activity");

   a_lo_match_8: assert property (
      lo_hit && !mode16 && s.irq_en[0] |=> lower_match_irq && (s.cnt_lo == 8'h00))
      else $error("8-bit lower match did not clear and interrupt");

   a_lo_quiet_16: assert property (
      mode16 && lo_hit && !joint |=> !lower_match_irq
                                   && (s.cnt_lo == $past(lo_next)))
      else $error("16-bit lower match cleared or interrupted");

   a_joint_clear: assert property (
      seq_joint_hit ##0 s.irq_en[1] |=> seq_both_cleared ##0 upper_match_irq)
      else $error("joint match did not clear both and interrupt");

   a_joint_toggle: assert property (
      seq_joint_hit ##0 s.ff_ie && !wr_ffcr |=> s.ff != $past(s.ff))
      else $error("joint match did not toggle output flop");

   a_cascade_count: assert property (
      !mode16 && s.run[1] && (s.hi_sel == 2'b00) && lo_hit && !hi_hit8
      |=> s.cnt_hi == 8'($past(s.cnt_hi) + 8'h01))
      else $error("upper counter missed a lower match pulse");

   a_upper_ovf_clock: assert property (
      mode16 && s.run[1] && lo_ovf && !joint
      |=> s.cnt_hi == 8'($past(s.cnt_hi) + 8'h01))
      else $error("16-bit upper counter missed lower overflow");

   a_upper_hold_16: assert property (
      mode16 && s.run[1] && !lo_ovf && !joint |=> $stable(s.cnt_hi))
      else $error("16-bit upper counter moved without overflow");

   a_cmp_inhibit: assert property (
      wr_cmp_lo && !wr_cmp_hi |=> !s.cmp16_en ##0 !joint)
      else $error("lower compare write left 16-bit compare on");

   a_flop_set: assert property (
      wr_ffcr && (wb[`CITP_FFCR_ACT_LSB +: 2] == 2'b01) |=> timer_output_pin)
      else $error("flop set action ignored");

   a_flop_clear: assert property (
      wr_ffcr && (wb[`CITP_FFCR_ACT_LSB +: 2] == 2'b10) |=> !timer_output_pin)
      else $error("flop clear action ignored");

   a_src_toggle: assert property (
      !mode16 && s.ff_ie && !s.ff_is && lo_hit && !wr_ffcr
      |=> timer_output_pin != $past(timer_output_pin))
      else $error("lower match did not toggle selected flop");

   a_no_inv_hold: assert property (
      !s.ff_ie && !wr_ffcr |=> $stable(timer_output_pin))
      else $error("output flop moved with inversion disabled");

   a_zero_is_256: assert property (
      lo_tick && !mode16 && (s.cmp_lo == 8'h00) && (s.cnt_lo == 8'hff) |-> lo_hit)
      else $error("compare 00 did not match on overflow");

endmodule

// file: rtl/citp_cfg.svh
// Constants of the cascadable interval timer pair: offsets, fields, resets, timing
`ifndef CITP_CFG_SVH
`define CITP_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CITP_OFF_RUN      8'h00
`define CITP_OFF_MODE     8'h04
`define CITP_OFF_CMP_LO   8'h08
`define CITP_OFF_CMP_HI   8'h0c
`define CITP_OFF_FFCR     8'h10
`define CITP_OFF_STATUS   8'h14
`define CITP_OFF_IRQ_EN   8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CITP_MODE_OP_LSB  6
`define CITP_MODE_HI_LSB  2
`define CITP_MODE_LO_LSB  0
`define CITP_FFCR_ACT_LSB 2
`define CITP_FFCR_IE_BIT  1
`define CITP_FFCR_IS_BIT  0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CITP_RST_FF_ACT   2'h3
`define CITP_RST_CMP      8'h00
`define CITP_RST_CMP16_EN 1'b1

// ----------------------------------------------------------------------------
// Timing: clk cycles per prescale_tap_1 (10 ns clk, 80 ns tap)
// ----------------------------------------------------------------------------
`define CITP_T1_DIV       8
`define CITP_PRE_W        11

`endif

// file: rtl/citp_pkg.sv
// Types shared by the timer pair, its prescaler and its register slave
package citp_pkg;

   typedef logic [7:0] citp_addr_t;

   typedef enum logic [1:0] {
      CITP_MODE_8BIT  = 2'b00,
      CITP_MODE_16BIT = 2'b01,
      CITP_MODE_PPG   = 2'b10,
      CITP_MODE_PWM   = 2'b11
   } citp_mode_e;

   typedef struct packed {
      citp_addr_t  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      citp_addr_t  araddr;
      logic        arvalid;
      logic        rready;
   } citp_axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } citp_axil_rsp_s;

   typedef struct packed {
      logic [1:0] run;
      citp_mode_e mode;
      logic [1:0] hi_sel;
      logic [1:0] lo_sel;
      logic [7:0] cmp_lo;
      logic [7:0] cmp_hi;
      logic       cmp16_en;
      logic [1:0] ff_act;
      logic       ff_ie;
      logic       ff_is;
      logic [1:0] irq_en;
      logic [7:0] cnt_lo;
      logic [7:0] cnt_hi;
      logic       ff;
      logic       ext_d;
      logic       irq_lo;
      logic       irq_hi;
   } citp_regs_s;

endpackage

// file: rtl/citp_prescaler.sv
// Free-running prescaler giving one-cycle enables for the four clock taps
`timescale 1ns/100ps
`include "citp_cfg.svh"
module citp_prescaler #(
   parameter int T1_DIV = `CITP_T1_DIV
) (
   input  wire logic       clk,
   input  wire logic       rst,
   output logic [3:0]      tap
);
   import citp_pkg::*;

   // Taps are T1, T4, T16, PRESCALE_TAP_256; all ratios must be powers of two
   localparam int RATIO [4] = '{1, 4, 16, 256};

   typedef struct packed {
      logic [`CITP_PRE_W-1:0] cnt;
      logic [3:0]             tap;
   } citp_pre_s;

   citp_pre_s s;
   citp_pre_s next_s;
   logic [3:0] hit;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_tap
         localparam logic [`CITP_PRE_W-1:0] MASK = `CITP_PRE_W'(T1_DIV * RATIO[g] - 1);
         assign hit[g] = (s.cnt & MASK) == MASK;
      end
   endgenerate

   always_comb begin
      next_s     = s;
      next_s.cnt = `CITP_PRE_W'(s.cnt + 1'b1);
      next_s.tap = hit;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tap = s.tap;
endmodule

// file: rtl/citp_axil_slave.sv
// AXI4-Lite slave: one write and one read in flight, registered answers
`timescale 1ns/100ps
module citp_axil_slave (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  citp_pkg::citp_axil_req_s  req,
   output citp_pkg::citp_axil_rsp_s  rsp,
   output logic                      wr_en,
   output citp_pkg::citp_addr_t      wr_addr,
   output logic [31:0]               wr_data,
   output logic [3:0]                wr_strb,
   input  wire logic                 wr_err,
   output citp_pkg::citp_addr_t      rd_addr,
   input  wire logic [31:0]          rd_data,
   input  wire logic                 rd_err
);
   import citp_pkg::*;

   typedef struct packed {
      logic           aw_held;
      citp_addr_t     awaddr;
      logic           w_held;
      logic [31:0]    wdata;
      logic [3:0]     wstrb;
      citp_axil_rsp_s r;
   } citp_slv_s;

   citp_slv_s s;
   citp_slv_s next_s;

   assign wr_en   = s.aw_held && s.w_held && !s.r.bvalid;
   assign wr_addr = s.awaddr;
   assign wr_data = s.wdata;
   assign wr_strb = s.wstrb;
   assign rd_addr = req.araddr;

   always_comb begin
      next_s = s;
      if (req.awvalid && s.r.awready) begin
         next_s.aw_held = 1'b1;
         next_s.awaddr  = req.awaddr;
      end
      if (req.wvalid && s.r.wready) begin
         next_s.w_held = 1'b1;
         next_s.wdata  = req.wdata;
         next_s.wstrb  = req.wstrb;
      end
      if (wr_en) begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.r.bvalid = 1'b1;
         next_s.r.bresp  = wr_err ? 2'h2 : 2'h0;
      end else if (s.r.bvalid && req.bready) begin
         next_s.r.bvalid = 1'b0;
      end
      if (req.arvalid && s.r.arready) begin
         next_s.r.rvalid = 1'b1;
         next_s.r.rdata  = rd_err ? 32'h0000_0000 : rd_data;
         next_s.r.rresp  = rd_err ? 2'h2 : 2'h0;
      end else if (s.r.rvalid && req.rready) begin
         next_s.r.rvalid = 1'b0;
      end
      // Readies are registered so every bus output comes from a flop
      next_s.r.awready = !next_s.aw_held && !next_s.r.bvalid;
      next_s.r.wready  = !next_s.w_held && !next_s.r.bvalid;
      next_s.r.arready = !next_s.r.rvalid;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rsp = s.r;
endmodule

// file: tb/tb.sv
// Self-checking bench of the cascadable interval timer pair
`timescale 1ns/100ps
`include "citp_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb;
   import citp_pkg::*;

   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  ext_pin = 1'b0;
   logic                  ext_run = 1'b0;
   citp_axil_req_s        req = '0;
   citp_axil_rsp_s        rsp;
   logic                  pin;
   logic                  irq_lo;
   logic                  irq_hi;
   int                    err_total = 0;
   int                    compares = 0;
   logic [33:0]           exp_q[$];
   logic [1:0]            acts[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
   logic                  ffs[4]  = '{1'b1, 1'b0, 1'b1, 1'b1};

   // Short tap divider keeps the 16-bit period cheap
   citp_timer_pair #(.T1_DIV(2)) i_citp_timer_pair (
      .clk                (clk),
      .rst                (rst),
      .axil_req           (req),
      .axil_rsp           (rsp),
      .external_count_pin (ext_pin),
      .timer_output_pin   (pin),
      .lower_match_irq    (irq_lo),
      .upper_match_irq    (irq_hi)
   );

   always #5 clk = ~clk;

   // Rising edge every two clocks while enabled
   always @(posedge clk) begin
      if (ext_run) ext_pin <= ~ext_pin;
   end

   // ------------------------------------------------------------------------
   // Response watcher: oldest note against each answer
   // ------------------------------------------------------------------------
   always @(posedge clk) begin
      logic [33:0] e;
      if (rsp.bvalid && req.bready) begin
         e = exp_q.pop_front();
         `CHK(rsp.bresp, e[33:32])
      end
      if (rsp.rvalid && req.rready) begin
         e = exp_q.pop_front();
         `CHK({rsp.rresp, rsp.rdata}, e)
      end
   end

   // ------------------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------------------
   task automatic wr(input citp_addr_t a, input logic [7:0] d, input logic [1:0] r = 2'b00);
      bit aw;
      bit w;
      exp_q.push_back({r, 32'h0});
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      req.wvalid <= 1'b1;
      aw = 0;
      w = 0;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && rsp.awready === 1'b1) begin
            aw = 1;
            req.awvalid <= 1'b0;
         end
         if (!w && rsp.wready === 1'b1) begin
            w = 1;
            req.wvalid <= 1'b0;
         end
      end
      // Raised only here so back-to-back calls never drive it twice in one step
      req.bready <= 1'b1;
      do @(posedge clk); while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask

   task automatic rd(input citp_addr_t a, input logic [31:0] d, input logic [1:0] r = 2'b00);
      exp_q.push_back({r, d});
      req.araddr <= a;
      req.arvalid <= 1'b1;
      do @(posedge clk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      req.rready <= 1'b1;
      do @(posedge clk); while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
   endtask

   // Interval between two irq pulses, pin flip over it, stray lower pulses
   task automatic per(input bit hi, input int exp, input bit tog, input bit quiet);
      int   n;
      int   o;
      logic p0;
      n = 0;
      o = 0;
      do begin @(posedge clk); n++; end
      while ((hi ? irq_hi : irq_lo) !== 1'b1 && n < 3000);
      p0 = pin;
      n = 0;
      do begin @(posedge clk); n++; o += irq_lo; end
      while ((hi ? irq_hi : irq_lo) !== 1'b1 && n < 3000);
      `CHK(n, exp)
      `CHK(pin, tog ? ~p0 : p0)
      if (quiet) `CHK(o, 0)
   endtask

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      #500000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      int         c;
      int         s;
      int         n;
      void'($urandom(82));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`CITP_OFF_RUN, 32'h0);
      rd(`CITP_OFF_MODE, 32'h0);
      rd(`CITP_OFF_CMP_LO, 32'h0);
      rd(`CITP_OFF_CMP_HI, 32'h0);
      rd(`CITP_OFF_FFCR, 32'hfc);
      rd(`CITP_OFF_STATUS, 32'h20000);
      rd(`CITP_OFF_IRQ_EN, 32'h0);
      rd(8'h1c, 32'h0, 2'b10);
      wr(`CITP_OFF_STATUS, 8'h01, 2'b10);
      $display("test register map done");

      wr(`CITP_OFF_RUN, 8'h00);
      wr(`CITP_OFF_MODE, 8'h04);
      wr(`CITP_OFF_CMP_HI, 8'h03);
      wr(`CITP_OFF_FFCR, 8'h0b);
      wr(`CITP_OFF_IRQ_EN, 8'h02);
      wr(`CITP_OFF_RUN, 8'h02);
      per(1, 6, 1, 1);
      wr(`CITP_OFF_RUN, 8'h00);
      wr(`CITP_OFF_FFCR, 8'h08);
      rd(`CITP_OFF_STATUS, 32'h20000);
      n = 0;
      repeat (60) begin @(posedge clk); n += irq_hi + irq_lo; end
      `CHK(n, 0)
      $display("test upper interval done");

      for (int i = 0; i < 4; i++) begin
         wr(`CITP_OFF_FFCR, {4'h0, acts[i], 2'b00});
         rd(`CITP_OFF_FFCR, {24'h0, 4'hf, acts[i], 2'b00});
         rd(`CITP_OFF_STATUS, {14'h0, 1'b1, ffs[i], 16'h0});
      end
      $display("test flop actions done");

      wr(`CITP_OFF_CMP_LO, 8'h02);
      rd(`CITP_OFF_STATUS, 32'h10000);
      wr(`CITP_OFF_CMP_HI, 8'h01);
      rd(`CITP_OFF_STATUS, 32'h30000);
      // Upper select at slowest tap: must be ignored when cascaded
      wr(`CITP_OFF_MODE, 8'h4d);
      wr(`CITP_OFF_FFCR, 8'h0a);
      wr(`CITP_OFF_IRQ_EN, 8'h03);
      wr(`CITP_OFF_RUN, 8'h03);
      per(1, 516, 1, 1);
      $display("test cascaded interval done");

      for (int i = 0; i < 5; i++) begin
         s = (i == 4) ? 1 : 1 + $urandom % 3;
         c = (i == 4) ? 0 : 1 + $urandom % 6;
         wr(`CITP_OFF_RUN, 8'h00);
         wr(`CITP_OFF_MODE, 8'(s));
         wr(`CITP_OFF_CMP_LO, 8'(c));
         wr(`CITP_OFF_FFCR, 8'h08);
         wr(`CITP_OFF_RUN, 8'h01);
         per(0, ((c == 0) ? 256 : c) * (2 << (2 * (s - 1))), 0, 0);
      end
      $display("test lower taps done");

      // Upper timer alone on its two slow taps
      for (int h = 2; h < 4; h++) begin
         wr(`CITP_OFF_RUN, 8'h00);
         wr(`CITP_OFF_MODE, 8'(h << 2));
         wr(`CITP_OFF_CMP_HI, 8'h02);
         wr(`CITP_OFF_RUN, 8'h02);
         per(1, 2 * (2 << (4 * (h - 1))), 0, 1);
      end
      $display("test upper taps done");

      wr(`CITP_OFF_RUN, 8'h00);
      wr(`CITP_OFF_MODE, 8'h01);
      wr(`CITP_OFF_CMP_LO, 8'h02);
      wr(`CITP_OFF_CMP_HI, 8'h03);
      wr(`CITP_OFF_FFCR, 8'h0b);
      wr(`CITP_OFF_RUN, 8'h03);
      per(1, 12, 1, 0);
      $display("test chained upper done");

      wr(`CITP_OFF_RUN, 8'h00);
      wr(`CITP_OFF_MODE, 8'h00);
      wr(`CITP_OFF_CMP_LO, 8'h03);
      wr(`CITP_OFF_FFCR, 8'h0a);
      ext_run <= 1'b1;
      wr(`CITP_OFF_RUN, 8'h01);
      per(0, 6, 1, 0);
      ext_run <= 1'b0;
      $display("test external count done");
      tally_and_finish();
   end
endmodule
